// File: rtl/tcc_pkg.sv
// Package for the timer compare and capture channel block
package tcc_pkg;
   localparam int TCC_NCMP = 4;
   localparam int TCC_NCAP = 2;
   localparam logic [4:0] TCC_A_CCR0  = 5'h00; // Control A..D at 00..03
   localparam logic [4:0] TCC_A_OCH0  = 5'h04; // Compare high A..D at 04..07
   localparam logic [4:0] TCC_A_OCL0  = 5'h08; // Compare low A..D at 08..0b
   localparam logic [4:0] TCC_A_ICL0  = 5'h0c; // Capture low A,B at 0c,0d
   localparam logic [4:0] TCC_A_ICH0  = 5'h0e; // Capture high A,B at 0e,0f
   localparam logic [4:0] TCC_A_FLAG  = 5'h10; // Flags: [3:0] compare, [5:4] capture
   localparam logic [4:0] TCC_A_IEN   = 5'h11; // Enables, same layout, [7] unit, [6] global
   localparam logic [4:0] TCC_A_UPD   = 5'h12; // [7] update request
   localparam logic [4:0] TCC_A_TORH  = 5'h13;
   localparam logic [4:0] TCC_A_TORL  = 5'h14;
   localparam int TCC_B_OCM = 0;
   localparam int TCC_B_FCO = 2;
   localparam int TCC_B_ICNF = 3;
   localparam int TCC_B_ICES = 4;
   localparam int TCC_B_ICEC = 5;
   localparam int TCC_B_UPD = 7;
   localparam int TCC_B_UNIT = 7;
   localparam int TCC_B_GLOB = 6;
   localparam int TCC_B_CAPF = 4;
   localparam logic [1:0] TCC_OCM_OFF = 2'h0;
   localparam logic [1:0] TCC_OCM_SETCLR = 2'h1;
   localparam logic [1:0] TCC_OCM_TOGGLE = 2'h3;
   localparam logic [7:0] TCC_RST8 = 8'h00;
   localparam logic [15:0] TCC_TOR_RST = 16'hffff;
   localparam logic [1:0] TCC_NF_SAMPLES = 2'h3; // Four equal samples: three repeats
   localparam logic [3:0] TCC_DLY6 = 4'h7;
   localparam logic [3:0] TCC_DLY7 = 4'hf;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcc_bus_t;
   typedef struct packed {
      logic [15:0] count;
      logic        pwm;
      logic        ovf;
   } tcc_timer_t;
endpackage : tcc_pkg

// File: rtl/tcc_top.sv
// Compare and capture channels of the unit timer with their register file
`timescale 1ns/1ns
module tcc_top
(
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             rst_in,
   // Register port
   input  wire tcc_pkg::tcc_bus_t bus_in,
   output logic [7:0]            rdata_out,
   // Timer core
   input  wire tcc_pkg::tcc_timer_t tmr_in,
   // Pins
   input  wire logic [1:0]       cap_pin_in,
   output logic [3:0]            cmp_pin_out,
   output logic [3:0]            cmp_pin_oe_out,
   // Reload value and interrupt request
   output logic [15:0]           reload_out,
   output logic                  irq_out
);
   import tcc_pkg::*;

   logic [7:0]  ccr_q [TCC_NCMP];
   logic [7:0]  och_sh_q [TCC_NCMP];
   logic [7:0]  ocl_sh_q [TCC_NCMP];
   logic [15:0] ocr_q [TCC_NCMP];
   logic [15:0] tor_sh_q;
   logic [15:0] tor_q;
   logic        upd_pend_q;
   logic [3:0]  cmpf_q;
   logic [3:0]  latch_q;
   logic [1:0]  capf_q;
   logic [15:0] icr_q [TCC_NCAP];
   logic [7:0]  ich_sh_q [TCC_NCAP];
   logic [7:0]  ien_q;
   logic [7:0]  rdata_q;
   logic [1:0]  smp_q [TCC_NCAP];
   logic [1:0]  flt_q;
   logic [1:0]  nf_cnt_q [TCC_NCAP];
   logic [1:0]  prev_q;
   logic [3:0]  evcnt_q [TCC_NCAP];
   logic        div_q;

   wire [15:0] range_max = tor_q;
   wire        wr_upd = bus_in.wr && bus_in.addr == TCC_A_UPD && bus_in.wdata[TCC_B_UPD];
   wire        do_xfer = (wr_upd && !tmr_in.pwm) || (upd_pend_q && tmr_in.pwm && tmr_in.ovf);
   wire        wr_flag = bus_in.wr && bus_in.addr == TCC_A_FLAG;
   wire        irq_gate = ien_q[TCC_B_GLOB] && ien_q[TCC_B_UNIT];

   logic [3:0] match;
   logic [3:0] force_w;
   logic [3:0] latch_d;
   logic [1:0] cap_ev;
   logic [1:0] edge_w;
   logic [3:0] dly_w [TCC_NCAP];

   // Compare logic per channel
   always_comb
   begin
      for (int i = 0; i < TCC_NCMP; i++)
      begin
         match[i] = ccr_q[i][TCC_B_OCM +: 2] != TCC_OCM_OFF
                    && tmr_in.count == ocr_q[i] && ocr_q[i] <= range_max;
         force_w[i] = bus_in.wr && bus_in.addr == TCC_A_CCR0 + 5'(i) && bus_in.wdata[TCC_B_FCO]
                      && bus_in.wdata[TCC_B_OCM +: 2] != TCC_OCM_OFF;
         latch_d[i] = latch_q[i];
         if (match[i] || force_w[i])
         begin
            // A forced compare follows the mode being written with it
            case (force_w[i] ? bus_in.wdata[TCC_B_OCM +: 2] : ccr_q[i][TCC_B_OCM +: 2])
               TCC_OCM_SETCLR: latch_d[i] = 1'b0;
               TCC_OCM_TOGGLE: latch_d[i] = ~latch_q[i];
               default: latch_d[i] = latch_q[i];
            endcase
         end
      end
   end

   // Capture edge qualification: filter samples every two core clocks
   always_comb
   begin
      for (int j = 0; j < TCC_NCAP; j++)
      begin
         edge_w[j] = ccr_q[j][TCC_B_ICES] ? (flt_q[j] && !prev_q[j]) : (!flt_q[j] && prev_q[j]);
         case (ccr_q[j][TCC_B_ICEC +: 3])
            3'h6: dly_w[j] = TCC_DLY6;
            3'h7: dly_w[j] = TCC_DLY7;
            default: dly_w[j] = {1'b0, ccr_q[j][TCC_B_ICEC +: 3]};
         endcase
         cap_ev[j] = edge_w[j] && evcnt_q[j] >= dly_w[j];
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < TCC_NCMP; i++)
         begin
            ccr_q[i] <= TCC_RST8;
            och_sh_q[i] <= TCC_RST8;
            ocl_sh_q[i] <= TCC_RST8;
            ocr_q[i] <= '0;
         end
         for (int j = 0; j < TCC_NCAP; j++)
         begin
            icr_q[j] <= '0;
            ich_sh_q[j] <= TCC_RST8;
            smp_q[j] <= '0;
            nf_cnt_q[j] <= '0;
            evcnt_q[j] <= '0;
         end
         tor_sh_q <= TCC_TOR_RST;
         tor_q <= TCC_TOR_RST;
         upd_pend_q <= 1'b0;
         cmpf_q <= '0;
         latch_q <= '0;
         capf_q <= '0;
         ien_q <= TCC_RST8;
         rdata_q <= TCC_RST8;
         flt_q <= '0;
         prev_q <= '0;
         div_q <= 1'b0;
      end
      else
      begin
         div_q <= ~div_q;
         latch_q <= latch_d;
         for (int i = 0; i < TCC_NCMP; i++)
         begin
            if (bus_in.wr && bus_in.addr == TCC_A_CCR0 + 5'(i))
            begin
               ccr_q[i] <= bus_in.wdata;
               if (!tmr_in.pwm)
                  ccr_q[i][TCC_B_FCO] <= 1'b0;
               // Starting a set/clear action drives the latch high
               if (bus_in.wdata[TCC_B_OCM +: 2] == TCC_OCM_SETCLR && ccr_q[i][TCC_B_OCM +: 2] == TCC_OCM_OFF)
                  latch_q[i] <= 1'b1;
            end
            if (bus_in.wr && bus_in.addr == TCC_A_OCH0 + 5'(i))
               och_sh_q[i] <= bus_in.wdata;
            if (bus_in.wr && bus_in.addr == TCC_A_OCL0 + 5'(i))
               ocl_sh_q[i] <= bus_in.wdata;
            if (do_xfer)
               ocr_q[i] <= {och_sh_q[i], ocl_sh_q[i]};
         end
         if (bus_in.wr && bus_in.addr == TCC_A_TORH)
            tor_sh_q[15:8] <= bus_in.wdata;
         if (bus_in.wr && bus_in.addr == TCC_A_TORL)
            tor_sh_q[7:0] <= bus_in.wdata;
         if (do_xfer)
            tor_q <= tor_sh_q;
         // A new request in the overflow cycle stays pending
         if (wr_upd && tmr_in.pwm)
            upd_pend_q <= 1'b1;
         else if (do_xfer)
            upd_pend_q <= 1'b0;
         if (bus_in.wr && bus_in.addr == TCC_A_IEN)
            ien_q <= bus_in.wdata;
         // Set wins over a software clear in the same cycle
         cmpf_q <= (wr_flag ? (cmpf_q & bus_in.wdata[3:0]) : cmpf_q) | match;
         capf_q <= (wr_flag ? (capf_q & bus_in.wdata[TCC_B_CAPF +: 2]) : capf_q) | cap_ev;
         for (int j = 0; j < TCC_NCAP; j++)
         begin
            if (div_q)
            begin
               smp_q[j] <= {smp_q[j][0], cap_pin_in[j]};
               if (!ccr_q[j][TCC_B_ICNF] || smp_q[j][0] == flt_q[j])
               begin
                  nf_cnt_q[j] <= '0;
                  if (!ccr_q[j][TCC_B_ICNF])
                     flt_q[j] <= smp_q[j][0];
               end
               else if (nf_cnt_q[j] == TCC_NF_SAMPLES)
               begin
                  nf_cnt_q[j] <= '0;
                  flt_q[j] <= smp_q[j][0];
               end
               else
                  nf_cnt_q[j] <= nf_cnt_q[j] + 2'h1;
            end
            prev_q[j] <= flt_q[j];
            if (cap_ev[j])
            begin
               icr_q[j] <= tmr_in.count;
               evcnt_q[j] <= '0;
            end
            else if (edge_w[j])
               evcnt_q[j] <= evcnt_q[j] + 4'h1;
            if (bus_in.rd && bus_in.addr == TCC_A_ICL0 + 5'(j))
               ich_sh_q[j] <= icr_q[j][15:8];
         end
         rdata_q <= rd_mux(bus_in.addr);
      end
   end

   function automatic logic [7:0] rd_mux(input logic [4:0] a);
      logic [7:0] r;
      r = TCC_RST8;
      for (int i = 0; i < TCC_NCMP; i++)
      begin
         if (a == TCC_A_CCR0 + 5'(i))
         begin
            r = ccr_q[i];
            // A force bit written in PWM mode must not show after a switch to basic mode
            if (!tmr_in.pwm)
               r[TCC_B_FCO] = 1'b0;
         end
         if (a == TCC_A_OCH0 + 5'(i))
            r = och_sh_q[i];
         if (a == TCC_A_OCL0 + 5'(i))
            r = ocl_sh_q[i];
      end
      for (int j = 0; j < TCC_NCAP; j++)
      begin
         if (a == TCC_A_ICL0 + 5'(j))
            r = icr_q[j][7:0];
         if (a == TCC_A_ICH0 + 5'(j))
            r = ich_sh_q[j];
      end
      if (a == TCC_A_FLAG)
         r = {2'h0, capf_q, cmpf_q};
      if (a == TCC_A_IEN)
         r = ien_q;
      if (a == TCC_A_UPD)
         r = {upd_pend_q && tmr_in.pwm, 7'h00};
      if (a == TCC_A_TORH)
         r = tor_sh_q[15:8];
      if (a == TCC_A_TORL)
         r = tor_sh_q[7:0];
      return r;
   endfunction : rd_mux

   wire [5:0] pend = {capf_q, cmpf_q} & ien_q[5:0];

   always_comb
   begin
      for (int i = 0; i < TCC_NCMP; i++)
      begin
         cmp_pin_oe_out[i] = ccr_q[i][TCC_B_OCM +: 2] != TCC_OCM_OFF;
         cmp_pin_out[i] = cmp_pin_oe_out[i] & latch_q[i];
      end
   end

   assign irq_out = irq_gate && |pend;
   assign rdata_out = rdata_q;
   assign reload_out = tor_q;

   AST_FLAG_LATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      match[0] |=> cmpf_q[0]) else $error("compare flag not set after match");
   AST_FLAG_STICKY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cmpf_q[1] && !wr_flag |=> cmpf_q[1]) else $error("compare flag cleared by hardware");
   AST_IRQ_GATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      irq_out |-> ien_q[TCC_B_UNIT] && ien_q[TCC_B_GLOB]) else $error("interrupt without enables");
   AST_OFF_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ccr_q[2][1:0] == TCC_OCM_OFF |-> !match[2] && !cmp_pin_oe_out[2]) else $error("disabled channel acts");
   AST_PIN_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !match[0] && !force_w[0] && !bus_in.wr |=> $stable(latch_q[0])) else $error("pin moved without event");
   AST_BASIC_NOPEND: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_upd && !tmr_in.pwm |=> ocr_q[0] == $past({och_sh_q[0], ocl_sh_q[0]}) && !upd_pend_q)
      else $error("basic update failed");
   sequence s_req;
      wr_upd && tmr_in.pwm;
   endsequence
   AST_PWM_PEND: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_req ##1 (!tmr_in.ovf) |-> upd_pend_q) else $error("update not pending");
   AST_CAPTURE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cap_ev[1] |=> icr_q[1] == $past(tmr_in.count) && capf_q[1]) else $error("capture lost");
   AST_RANGE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ocr_q[3] > tor_q |-> !match[3]) else $error("out-of-range match");

   sequence s_low_read;
      bus_in.rd && bus_in.addr == TCC_A_ICL0;
   endsequence

   sequence s_xfer;
      do_xfer;
   endsequence

   sequence s_pwm_done;
      upd_pend_q && tmr_in.pwm && tmr_in.ovf && !wr_upd;
   endsequence

   AST_FCO_BASIC: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      bus_in.wr && bus_in.addr == TCC_A_CCR0 && !tmr_in.pwm
      |=> !ccr_q[0][TCC_B_FCO])
      else $error("force bit kept in basic mode");

   AST_FORCE_NOFLAG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      force_w[1] && !match[1] && !cmpf_q[1]
      |=> !cmpf_q[1])
      else $error("forced compare set the flag");

   AST_FORCE_MOVE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      force_w[1] && !match[1] && bus_in.wdata[TCC_B_OCM +: 2] == TCC_OCM_TOGGLE
      |=> latch_q[1] != $past(latch_q[1]))
      else $error("forced toggle did not move the latch");

   AST_TOGGLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      match[1] && ccr_q[1][TCC_B_OCM +: 2] == TCC_OCM_TOGGLE && !(bus_in.wr && bus_in.addr == TCC_A_CCR0 + 5'h01)
      |=> latch_q[1] != $past(latch_q[1]))
      else $error("toggle mode did not toggle");

   AST_SETCLR_MATCH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      match[0] && ccr_q[0][TCC_B_OCM +: 2] == TCC_OCM_SETCLR && !(bus_in.wr && bus_in.addr == TCC_A_CCR0)
      |=> !latch_q[0])
      else $error("set/clear mode not cleared on match");

   AST_SETCLR_START: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      bus_in.wr && bus_in.addr == TCC_A_CCR0 && ccr_q[0][TCC_B_OCM +: 2] == TCC_OCM_OFF
      && bus_in.wdata[TCC_B_OCM +: 2] == TCC_OCM_SETCLR
      |=> latch_q[0])
      else $error("set/clear mode not set at start");

   AST_MATCH_NOIRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      match[3] && !ien_q[3] && ccr_q[3][TCC_B_OCM +: 2] == TCC_OCM_TOGGLE
      && !(bus_in.wr && bus_in.addr == TCC_A_CCR0 + 5'h03)
      |=> latch_q[3] != $past(latch_q[3]))
      else $error("pin action skipped with interrupt off");

   AST_FLAG_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      cmpf_q[2] && ien_q[2] && irq_gate
      |-> irq_out)
      else $error("enabled compare flag gave no request");

   AST_SHADOW_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !do_xfer
      |=> $stable(ocr_q[2]) && $stable(tor_q))
      else $error("active value changed without update");

   AST_XFER_ALL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_xfer
      |=> ocr_q[3] == $past({och_sh_q[3], ocl_sh_q[3]}) && tor_q == $past(tor_sh_q))
      else $error("update did not move every shadow");

   AST_UPD_READ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      bus_in.rd && bus_in.addr == TCC_A_UPD && !tmr_in.pwm
      |=> rdata_out == TCC_RST8)
      else $error("update bit read nonzero in basic mode");

   AST_PWM_DONE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_pwm_done
      |=> !upd_pend_q)
      else $error("pending update not cleared at overflow");

   AST_CAP_STICKY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      capf_q[0] && !wr_flag
      |=> capf_q[0])
      else $error("capture flag cleared by hardware");

   AST_CAP_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      wr_flag && !bus_in.wdata[TCC_B_CAPF] && !cap_ev[0]
      |=> !capf_q[0])
      else $error("capture flag not cleared by software");

   AST_CAP_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      capf_q[1] && ien_q[TCC_B_CAPF + 1] && irq_gate
      |-> irq_out)
      else $error("enabled capture flag gave no request");

   AST_CAP_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !cap_ev[0]
      |=> $stable(icr_q[0]))
      else $error("capture register moved without event");

   AST_DELAY_COUNT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      edge_w[0] && !cap_ev[0]
      |=> evcnt_q[0] == $past(evcnt_q[0]) + 4'h1)
      else $error("qualifying edge not counted");

   AST_FILTER_RATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !div_q
      |=> $stable(flt_q))
      else $error("input sampled off the two-clock rate");

   AST_ICH_SHADOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      s_low_read
      |=> ich_sh_q[0] == $past(icr_q[0][15:8]))
      else $error("low read did not refresh high shadow");

   AST_ICH_READ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      bus_in.rd && bus_in.addr == TCC_A_ICH0
      |=> rdata_out == $past(ich_sh_q[0]))
      else $error("high read did not return shadow");
endmodule : tcc_top

// File: verif/timer_compare_capture_channels_tb.sv
// Self-checking testbench for the compare and capture channel block
`timescale 1ns/1ns
module timer_compare_capture_channels_tb;
   import tcc_pkg::*;
   logic        ref_clk_in;
   logic        rst_in;
   tcc_bus_t    bus;
   tcc_timer_t  tmr;
   logic [1:0]  cap_pin;
   logic [7:0]  rdata;
   logic [3:0]  cmp_pin;
   logic [3:0]  cmp_oe;
   logic [15:0] reload;
   logic        irq;
   int          n_errors;
   int          n_tests;

   tcc_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata), .tmr_in(tmr),
                  .cap_pin_in(cap_pin), .cmp_pin_out(cmp_pin), .cmp_pin_oe_out(cmp_oe), .reload_out(reload),
                  .irq_out(irq));

   initial
   begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   task automatic conclude();
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data follow the bus address one cycle later, strobe or not; they are judged in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      bus.rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : cyc

   // Bounded wait on the interrupt request; running out ends the run
   task automatic wait_irq(input int n);
      for (int i = 0; i < n; i++)
      begin
         cyc(1);
         if (irq === 1'b1)
            return;
      end
      n_errors++;
      $display("MISMATCH at %0t: interrupt request never came", $time);
      conclude();
   endtask : wait_irq

   task automatic hit(input logic [15:0] v);
      @(posedge ref_clk_in);
      tmr.count <= v;
      @(posedge ref_clk_in);
      tmr.count <= 16'h5555;
   endtask : hit

   task automatic sc_reset();
      rd(TCC_A_CCR0, 8'h00);
      rd(TCC_A_FLAG, 8'h00);
      chk(reload, TCC_TOR_RST);
      chk({12'h000, cmp_pin, cmp_oe}, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
   endtask : sc_reset

   task automatic sc_compare();
      wr(TCC_A_IEN, 8'hc1);
      wr(TCC_A_OCH0, 8'h12);
      wr(TCC_A_OCL0, 8'h34);
      wr(TCC_A_OCH0 + 5'h01, 8'h12);
      wr(TCC_A_OCL0 + 5'h01, 8'h34);
      wr(TCC_A_CCR0, 8'h01);
      wr(TCC_A_CCR0 + 5'h01, 8'h03);
      cyc(2);
      chk({12'h000, cmp_pin, cmp_oe}, 16'h0013);
      // Shadows only: the match must not fire yet
      hit(16'h1234);
      cyc(4);
      chk({15'h0000, irq}, 16'h0000);
      wr(TCC_A_UPD, 8'h80);
      rd(TCC_A_UPD, 8'h00);
      hit(16'h1234);
      wait_irq(4);
      chk({12'h000, cmp_pin}, 16'h0002);
      cyc(20);
      rd(TCC_A_FLAG, 8'h03);
      wr(TCC_A_FLAG, 8'hfe);
      cyc(1);
      chk({15'h0000, irq}, 16'h0000);
      rd(TCC_A_FLAG, 8'h02);
      wr(TCC_A_CCR0 + 5'h01, 8'h07);
      cyc(2);
      chk({12'h000, cmp_pin}, 16'h0000);
      rd(TCC_A_FLAG, 8'h02);
      rd(TCC_A_CCR0 + 5'h01, 8'h03);
      cyc(10);
      chk({12'h000, cmp_pin}, 16'h0000);
   endtask : sc_compare

   task automatic sc_range_pwm();
      wr(TCC_A_FLAG, 8'h00);
      wr(TCC_A_TORH, 8'h01);
      wr(TCC_A_TORL, 8'h00);
      wr(TCC_A_OCH0 + 5'h02, 8'h02);
      wr(TCC_A_OCL0 + 5'h02, 8'h00);
      wr(TCC_A_CCR0 + 5'h02, 8'h03);
      wr(TCC_A_UPD, 8'h80);
      cyc(2);
      chk(reload, 16'h0100);
      hit(16'h0200);
      cyc(4);
      rd(TCC_A_FLAG, 8'h00);
      chk({12'h000, cmp_pin}, 16'h0000);
      @(posedge ref_clk_in);
      tmr.pwm <= 1'b1;
      wr(TCC_A_TORL, 8'h80);
      wr(TCC_A_UPD, 8'h80);
      rd(TCC_A_UPD, 8'h80);
      chk(reload, 16'h0100);
      @(posedge ref_clk_in);
      tmr.ovf <= 1'b1;
      @(posedge ref_clk_in);
      tmr.ovf <= 1'b0;
      cyc(2);
      rd(TCC_A_UPD, 8'h00);
      chk(reload, 16'h0180);
      @(posedge ref_clk_in);
      tmr.pwm <= 1'b0;
   endtask : sc_range_pwm

   task automatic sc_capture();
      wr(TCC_A_FLAG, 8'h00);
      wr(TCC_A_IEN, 8'hf0);
      wr(TCC_A_CCR0, 8'h30);
      wr(TCC_A_CCR0 + 5'h01, 8'h08);
      tmr.count <= 16'h9abc;
      cyc(2);
      // One edge is swallowed by the delay count
      cap_pin[0] <= 1'b1;
      cyc(10);
      cap_pin[0] <= 1'b0;
      cyc(10);
      chk({15'h0000, irq}, 16'h0000);
      cap_pin[0] <= 1'b1;
      wait_irq(20);
      rd(TCC_A_FLAG, 8'h10);
      rd(TCC_A_ICL0, 8'hbc);
      tmr.count <= 16'h1111;
      rd(TCC_A_ICH0, 8'h9a);
      wr(TCC_A_FLAG, 8'h00);
      cyc(1);
      chk({15'h0000, irq}, 16'h0000);
      // A short glitch must not pass the filter
      // Three samples of the new level are one short of the four needed
      cap_pin[1] <= 1'b0;
      cyc(6);
      cap_pin[1] <= 1'b1;
      cyc(30);
      chk({15'h0000, irq}, 16'h0000);
      tmr.count <= 16'h4321;
      cap_pin[1] <= 1'b0;
      wait_irq(30);
      rd(TCC_A_ICL0 + 5'h01, 8'h21);
      rd(TCC_A_ICL0 + 5'h01, 8'h21);
      rd(TCC_A_ICH0 + 5'h01, 8'h43);
      // Delay code 110: seven rising edges pass, the eighth captures
      wr(TCC_A_FLAG, 8'h00);
      wr(TCC_A_CCR0, 8'hd0);
      for (int k = 0; k < 7; k++)
      begin
         cap_pin[0] <= 1'b0;
         cyc(4);
         cap_pin[0] <= 1'b1;
         cyc(4);
      end
      chk({15'h0000, irq}, 16'h0000);
      cap_pin[0] <= 1'b0;
      cyc(4);
      cap_pin[0] <= 1'b1;
      wait_irq(20);
      rd(5'h1f, 8'h00);
   endtask : sc_capture

   initial
   begin
      n_errors = 0;
      n_tests = 0;
      rst_in = 1'b1;
      bus = '0;
      tmr = '{count: 16'h5555, pwm: 1'b0, ovf: 1'b0};
      cap_pin = 2'b10;
      repeat (20) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      sc_reset();
      sc_compare();
      sc_range_pwm();
      sc_capture();
      conclude();
   end
endmodule : timer_compare_capture_channels_tb
